//--- sfr_defines.svh
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// byte region of the bank
`define SFR_REGION_BASE 16'h0000
`define SFR_REGION_MASK 16'hFFF0

// register offsets within the region
`define SFR_OFS_IE1 4'h0
`define SFR_OFS_IE2 4'h1
`define SFR_OFS_INTERRUPT_FLAGS_ONE 4'h2
`define SFR_OFS_INTERRUPT_FLAGS_TWO 4'h3
`define SFR_OFS_ME1 4'h4
`define SFR_OFS_ME2 4'h5

// bit positions, shared by enable and flag registers; POR and RST are flag-only, ACCV enable-only
`define SFR_BIT_WDT 0
`define SFR_BIT_OSC 1
`define SFR_BIT_POR 2
`define SFR_BIT_RST 3
`define SFR_BIT_NMI 4
`define SFR_BIT_ACCV 5
`define SFR_BIT_RX 6
`define SFR_BIT_TX 7
`define SFR_BIT_UART_RX 6
`define SFR_BIT_UART_TX 7

// implemented bits
`define SFR_IE1_MASK 8'hF3
`define SFR_INTERRUPT_FLAGS_ONE_MASK 8'hDF
`define SFR_ME1_MASK 8'hC0

// initial values
`define SFR_IE1_PUC 8'h00
`define SFR_ME1_PUC 8'h00
`define SFR_INTERRUPT_FLAGS_ONE_PUC_BITS 8'hD2
`define SFR_INTERRUPT_FLAGS_ONE_PUC_VAL 8'h82
`define SFR_INTERRUPT_FLAGS_ONE_POR_BITS 8'h0D
`define SFR_INTERRUPT_FLAGS_ONE_POR_VAL 8'h04

`define SFR_ZERO8 8'h00

`endif

//--- sfr_pkg.sv
package sfr_pkg;

  typedef struct packed {
    logic [7:0] ie1;
    logic [7:0] interrupt_flags_one;
    logic [7:0] me1;
  } sfr_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } sfr_bus_req_t;

  typedef struct packed {
    sfr_regs_t regs;
    logic [7:0] rdata;
    logic hit;
  } sfr_state_t;

  typedef struct packed {
    logic wdt;
    logic osc;
    logic nmi;
    logic accv;
    logic rx;
    logic tx;
    logic uart_tx_en;
    logic uart_rx_en;
  } sfr_req_t;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] level;
    logic [1:0] rise;
  } sfr_sync_state_t;

endpackage

//--- sfr_pin_sync.sv
`timescale 1ns/100ps
`include "sfr_defines.svh"

module sfr_pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] raw,
  output logic [1:0] level,
  output logic [1:0] rise
);

  sfr_pkg::sfr_sync_state_t st;
  sfr_pkg::sfr_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.rise = 2'b00;
    for (int i = 0; i < 2; i++) begin
      // a change counts once second and third stage agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
        next_st.rise[i] = st.s3[i] & ~st.level[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign rise = st.rise;

endmodule

//--- sfr_irq_gate.sv
`timescale 1ns/100ps
`include "sfr_defines.svh"

module sfr_irq_gate (
  input wire logic clk,
  input wire logic rst,
  input sfr_pkg::sfr_regs_t regs,
  input wire logic wdt_interval_mode,
  input wire logic flash_violation,
  output sfr_pkg::sfr_req_t req
);

  sfr_pkg::sfr_req_t st;
  sfr_pkg::sfr_req_t next_st;

  always_comb begin
    next_st = st;
    next_st.wdt = regs.ie1[`SFR_BIT_WDT] & regs.interrupt_flags_one[`SFR_BIT_WDT] & wdt_interval_mode;
    next_st.osc = regs.ie1[`SFR_BIT_OSC] & regs.interrupt_flags_one[`SFR_BIT_OSC];
    next_st.nmi = regs.ie1[`SFR_BIT_NMI] & regs.interrupt_flags_one[`SFR_BIT_NMI];
    // flash violation flag lives in the flash module
    next_st.accv = regs.ie1[`SFR_BIT_ACCV] & flash_violation;
    next_st.rx = regs.ie1[`SFR_BIT_RX] & regs.interrupt_flags_one[`SFR_BIT_RX];
    next_st.tx = regs.ie1[`SFR_BIT_TX] & regs.interrupt_flags_one[`SFR_BIT_TX];
    next_st.uart_tx_en = regs.me1[`SFR_BIT_UART_TX];
    next_st.uart_rx_en = regs.me1[`SFR_BIT_UART_RX];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign req = st;

endmodule

//--- sfr_bank.sv
`timescale 1ns/100ps
`include "sfr_defines.svh"

module sfr_bank (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [7:0] RDATA,
  output logic HIT,
  input wire logic WDT_INTERVAL_MODE,
  input wire logic WDT_OVERFLOW,
  input wire logic WDT_KEY_VIOLATION,
  input wire logic PIN_NMI_MODE,
  input wire logic PIN_RESET_EVENT,
  input wire logic NMI_PIN,
  input wire logic OSC_FAULT,
  input wire logic FLASH_VIOLATION,
  input wire logic SERIAL_RX_SET,
  input wire logic SERIAL_TX_SET,
  output logic WDT_IRQ,
  output logic OSC_FAULT_IRQ,
  output logic NMI_IRQ,
  output logic FLASH_VIOLATION_IRQ,
  output logic SERIAL_RX_IRQ,
  output logic SERIAL_TX_IRQ,
  output logic UART_TX_MODULE_EN,
  output logic UART_RX_MODULE_EN,
  output logic SERIAL_RX_FLAG,
  output logic SERIAL_TX_FLAG
);

  sfr_pkg::sfr_state_t st;
  sfr_pkg::sfr_state_t next_st;
  sfr_pkg::sfr_bus_req_t bus;
  sfr_pkg::sfr_req_t req;
  logic [1:0] pin_level;
  logic [1:0] pin_rise;
  logic any_reset;

  ////////////////////////////////////////////////////////////////////////
  // pin-side inputs: bit 0 oscillator fault, bit 1 nmi pin

  assign any_reset = RST | POR;

  sfr_pin_sync u_sync (
    .clk(CLK),
    .rst(any_reset),
    .raw({NMI_PIN, OSC_FAULT}),
    .level(pin_level),
    .rise(pin_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // register state

  assign bus.addr = ADDR;
  assign bus.wdata = WDATA;
  assign bus.we = WE;
  assign bus.re = RE;

  always_comb begin
    logic in_region;
    logic [3:0] ofs;
    logic [7:0] set_bits;
    in_region = 1'b0;
    ofs = 4'h0;
    set_bits = `SFR_ZERO8;
    next_st = st;
    in_region = (bus.addr & `SFR_REGION_MASK) == `SFR_REGION_BASE;
    ofs = bus.addr[3:0];
    next_st.hit = in_region & (bus.re | bus.we);
    next_st.rdata = `SFR_ZERO8;

    if (bus.re && in_region) begin
      unique case (ofs)
        `SFR_OFS_IE1: next_st.rdata = st.regs.ie1 & `SFR_IE1_MASK;
        `SFR_OFS_INTERRUPT_FLAGS_ONE: next_st.rdata = st.regs.interrupt_flags_one & `SFR_INTERRUPT_FLAGS_ONE_MASK;
        `SFR_OFS_ME1: next_st.rdata = st.regs.me1 & `SFR_ME1_MASK;
        default: next_st.rdata = `SFR_ZERO8;
      endcase
    end

    if (bus.we && in_region) begin
      unique case (ofs)
        `SFR_OFS_IE1: next_st.regs.ie1 = bus.wdata & `SFR_IE1_MASK;
        `SFR_OFS_INTERRUPT_FLAGS_ONE: next_st.regs.interrupt_flags_one = bus.wdata & `SFR_INTERRUPT_FLAGS_ONE_MASK;
        `SFR_OFS_ME1: next_st.regs.me1 = bus.wdata & `SFR_ME1_MASK;
        default: next_st.regs = st.regs;
      endcase
    end

    set_bits[`SFR_BIT_WDT] = WDT_OVERFLOW | WDT_KEY_VIOLATION;
    set_bits[`SFR_BIT_OSC] = pin_level[0];
    set_bits[`SFR_BIT_RST] = PIN_RESET_EVENT;
    set_bits[`SFR_BIT_NMI] = pin_rise[1] & PIN_NMI_MODE;
    set_bits[`SFR_BIT_RX] = SERIAL_RX_SET;
    set_bits[`SFR_BIT_TX] = SERIAL_TX_SET;
    // set wins over a software clear
    next_st.regs.interrupt_flags_one = (next_st.regs.interrupt_flags_one | set_bits) & `SFR_INTERRUPT_FLAGS_ONE_MASK;

    if (PIN_RESET_EVENT) begin
      next_st.regs.interrupt_flags_one[`SFR_BIT_WDT] = 1'b0;
    end

    if (RST) begin
      next_st.regs.ie1 = `SFR_IE1_PUC;
      next_st.regs.me1 = `SFR_ME1_PUC;
      next_st.regs.interrupt_flags_one = (next_st.regs.interrupt_flags_one & `SFR_INTERRUPT_FLAGS_ONE_POR_BITS) | `SFR_INTERRUPT_FLAGS_ONE_PUC_VAL;
      next_st.rdata = `SFR_ZERO8;
      next_st.hit = 1'b0;
    end

    // power-on sets its flag and the osc and tx flags, clears the rest
    if (POR) begin
      next_st.regs.ie1 = `SFR_IE1_PUC;
      next_st.regs.me1 = `SFR_ME1_PUC;
      next_st.regs.interrupt_flags_one = `SFR_INTERRUPT_FLAGS_ONE_PUC_VAL | `SFR_INTERRUPT_FLAGS_ONE_POR_VAL;
      next_st.rdata = `SFR_ZERO8;
      next_st.hit = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // request outputs

  sfr_irq_gate u_gate (
    .clk(CLK),
    .rst(any_reset),
    .regs(st.regs),
    .wdt_interval_mode(WDT_INTERVAL_MODE),
    .flash_violation(FLASH_VIOLATION),
    .req(req)
  );

  assign RDATA = st.rdata;
  assign HIT = st.hit;
  assign WDT_IRQ = req.wdt;
  assign OSC_FAULT_IRQ = req.osc;
  assign NMI_IRQ = req.nmi;
  assign FLASH_VIOLATION_IRQ = req.accv;
  assign SERIAL_RX_IRQ = req.rx;
  assign SERIAL_TX_IRQ = req.tx;
  assign UART_TX_MODULE_EN = req.uart_tx_en;
  assign UART_RX_MODULE_EN = req.uart_rx_en;
  assign SERIAL_RX_FLAG = st.regs.interrupt_flags_one[`SFR_BIT_RX];
  assign SERIAL_TX_FLAG = st.regs.interrupt_flags_one[`SFR_BIT_TX];

endmodule

//--- sfr_bank_checker.sv
`timescale 1ns/100ps
module sfr_bank_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic [15:0] ADDR,
  input wire logic WE,
  input wire logic RE,
  input wire logic [7:0] RDATA,
  input wire logic HIT,
  input wire logic WDT_INTERVAL_MODE,
  input wire logic WDT_IRQ,
  input wire logic SERIAL_RX_SET,
  input wire logic SERIAL_RX_FLAG,
  input wire logic SERIAL_RX_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST || POR);
  logic in_reg;
  assign in_reg = ADDR[15:4] == 12'h000;
  property p_hit; (WE || RE) && in_reg |=> HIT; endproperty
  a_hit: assert property (p_hit) else $error("hit missing");
  property p_miss; !((WE || RE) && in_reg) |=> !HIT; endproperty
  a_miss: assert property (p_miss) else $error("stray hit");
  property p_empty; RE && in_reg && ADDR[3:0] inside {4'h1, 4'h3, 4'h5} |=> RDATA == 8'h00; endproperty
  a_empty: assert property (p_empty) else $error("empty byte not zero");
  property p_idle; !(RE && in_reg) |=> RDATA == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_ie; RE && ADDR == 16'h0000 |=> RDATA[3:2] == 2'h0; endproperty
  a_ie: assert property (p_ie) else $error("absent enable bits");
  property p_me; RE && ADDR == 16'h0004 |=> RDATA[5:0] == 6'h00; endproperty
  a_me: assert property (p_me) else $error("absent module bits");
  property p_rx; SERIAL_RX_SET |=> SERIAL_RX_FLAG; endproperty
  a_rx: assert property (p_rx) else $error("rx flag not set");
  property p_wdt; !WDT_INTERVAL_MODE |=> !WDT_IRQ; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog irq in watchdog mode");
  c_wr: cover property (WE && in_reg);
  c_wdt: cover property (WDT_IRQ);
  c_rx: cover property (SERIAL_RX_IRQ);
endmodule
bind sfr_bank sfr_bank_checker sfr_bank_checker_i (.CLK(CLK), .RST(RST), .POR(POR),
  .ADDR(ADDR), .WE(WE), .RE(RE), .RDATA(RDATA), .HIT(HIT),
  .WDT_INTERVAL_MODE(WDT_INTERVAL_MODE), .WDT_IRQ(WDT_IRQ), .SERIAL_RX_SET(SERIAL_RX_SET),
  .SERIAL_RX_FLAG(SERIAL_RX_FLAG), .SERIAL_RX_IRQ(SERIAL_RX_IRQ));

//--- sfr_cpu_model.sv
`timescale 1ns/100ps
module sfr_cpu_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic we,
  output logic re
);
  initial begin
    addr = 16'hFFFF;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
  end
  // idle bus shows inverted last address, and inverted data after a write
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    addr = ~a;
    d = rdata;
  endtask
endmodule

//--- tb_sfr_bank.sv
`timescale 1ns/100ps
module tb_sfr_bank;
  logic CLK, RST, POR, WE, RE, HIT, WDT_INTERVAL_MODE, WDT_OVERFLOW, WDT_KEY_VIOLATION;
  logic PIN_NMI_MODE, PIN_RESET_EVENT, NMI_PIN, OSC_FAULT, FLASH_VIOLATION, SERIAL_RX_SET;
  logic SERIAL_TX_SET, WDT_IRQ, OSC_FAULT_IRQ, NMI_IRQ, FLASH_VIOLATION_IRQ, SERIAL_RX_IRQ;
  logic SERIAL_TX_IRQ, UART_TX_MODULE_EN, UART_RX_MODULE_EN, SERIAL_RX_FLAG, SERIAL_TX_FLAG;
  logic [15:0] ADDR;
  logic [7:0] WDATA, RDATA;
  logic [4:0] ev;
  logic [7:0] mask [6] = '{8'hF3, 8'h00, 8'hDF, 8'h00, 8'hC0, 8'h00};
  int num_errors = 0, n_tests = 0, cyc = 0;
  assign {SERIAL_TX_SET, SERIAL_RX_SET, PIN_RESET_EVENT, WDT_KEY_VIOLATION, WDT_OVERFLOW} = ev;
  sfr_bank sfr_bank_i (.CLK(CLK), .RST(RST), .POR(POR), .ADDR(ADDR), .WDATA(WDATA), .WE(WE),
    .RE(RE), .RDATA(RDATA), .HIT(HIT), .WDT_INTERVAL_MODE(WDT_INTERVAL_MODE),
    .WDT_OVERFLOW(WDT_OVERFLOW), .WDT_KEY_VIOLATION(WDT_KEY_VIOLATION),
    .PIN_NMI_MODE(PIN_NMI_MODE), .PIN_RESET_EVENT(PIN_RESET_EVENT), .NMI_PIN(NMI_PIN),
    .OSC_FAULT(OSC_FAULT), .FLASH_VIOLATION(FLASH_VIOLATION),
    .SERIAL_RX_SET(SERIAL_RX_SET), .SERIAL_TX_SET(SERIAL_TX_SET), .WDT_IRQ(WDT_IRQ),
    .OSC_FAULT_IRQ(OSC_FAULT_IRQ), .NMI_IRQ(NMI_IRQ),
    .FLASH_VIOLATION_IRQ(FLASH_VIOLATION_IRQ), .SERIAL_RX_IRQ(SERIAL_RX_IRQ),
    .SERIAL_TX_IRQ(SERIAL_TX_IRQ), .UART_TX_MODULE_EN(UART_TX_MODULE_EN),
    .UART_RX_MODULE_EN(UART_RX_MODULE_EN), .SERIAL_RX_FLAG(SERIAL_RX_FLAG),
    .SERIAL_TX_FLAG(SERIAL_TX_FLAG));
  sfr_cpu_model sfr_cpu_model_i (.clk(CLK), .rdata(RDATA), .addr(ADDR), .wdata(WDATA),
    .we(WE), .re(RE));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      test_done;
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] v;
    sfr_cpu_model_i.rd(a, v);
    chk($sformatf("byte %h", a), v, e);
  endtask
  task automatic pulse(input logic [4:0] m);
    @(negedge CLK);
    ev = m;
    @(negedge CLK);
    ev = 5'h00;
  endtask
  initial begin
    RST = 1'b1;
    POR = 1'b1;
    ev = 5'h00;
    {WDT_INTERVAL_MODE, PIN_NMI_MODE, NMI_PIN, OSC_FAULT, FLASH_VIOLATION} = 5'h00;
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    POR = 1'b0;
    rc(16'h0002, 8'h86);
    rc(16'h0000, 8'h00);
    rc(16'h0004, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      sfr_cpu_model_i.wr(16'(i), 8'hFF);
      rc(16'(i), mask[i]);
    end
    chk("module enables", {6'h00, UART_TX_MODULE_EN, UART_RX_MODULE_EN}, 8'h03);
    rc(16'h0010, 8'h00);
    sfr_cpu_model_i.wr(16'h0002, 8'h00);
    rc(16'h0002, 8'h00);
    $display("register test done");
    pulse(5'h18);
    rc(16'h0002, 8'hC0);
    chk("serial irqs", {6'h00, SERIAL_TX_IRQ, SERIAL_RX_IRQ}, 8'h03);
    chk("serial flags", {6'h00, SERIAL_TX_FLAG, SERIAL_RX_FLAG}, 8'h03);
    sfr_cpu_model_i.wr(16'h0002, 8'h00);
    pulse(5'h01);
    rc(16'h0002, 8'h01);
    chk("wdt irq off", {7'h00, WDT_IRQ}, 8'h00);
    WDT_INTERVAL_MODE = 1'b1;
    repeat (2) @(negedge CLK);
    chk("wdt irq on", {7'h00, WDT_IRQ}, 8'h01);
    pulse(5'h04);
    rc(16'h0002, 8'h08);
    sfr_cpu_model_i.wr(16'h0002, 8'h00);
    pulse(5'h02);
    rc(16'h0002, 8'h01);
    OSC_FAULT = 1'b1;
    repeat (6) @(negedge CLK);
    OSC_FAULT = 1'b0;
    repeat (6) @(negedge CLK);
    rc(16'h0002, 8'h03);
    PIN_NMI_MODE = 1'b1;
    NMI_PIN = 1'b1;
    repeat (6) @(negedge CLK);
    rc(16'h0002, 8'h13);
    chk("osc nmi irqs", {6'h00, OSC_FAULT_IRQ, NMI_IRQ}, 8'h03);
    chk("flash irq off", {7'h00, FLASH_VIOLATION_IRQ}, 8'h00);
    FLASH_VIOLATION = 1'b1;
    repeat (2) @(negedge CLK);
    chk("flash irq on", {7'h00, FLASH_VIOLATION_IRQ}, 8'h01);
    FLASH_VIOLATION = 1'b0;
    NMI_PIN = 1'b0;
    $display("event test done");
    RST = 1'b1;
    @(negedge CLK);
    RST = 1'b0;
    rc(16'h0002, 8'h83);
    rc(16'h0000, 8'h00);
    chk("enables cleared", {6'h00, UART_TX_MODULE_EN, UART_RX_MODULE_EN}, 8'h00);
    $display("clear test done");
    pulse(5'h05);
    rc(16'h0002, 8'h8A);
    pulse(5'h01);
    POR = 1'b1;
    @(negedge CLK);
    POR = 1'b0;
    rc(16'h0002, 8'h86);
    $display("power-on test done");
    test_done;
  end
endmodule
